// [inc/aessc_defs.svh]
// register offsets, field positions, command codes and timing counts
`ifndef AESSC_DEFS_SVH
`define AESSC_DEFS_SVH
`define AESSC_OFF_ENV1 8'h00
`define AESSC_OFF_PRMD 8'h04
`define AESSC_OFF_STS 8'h08
`define AESSC_OFF_ERR 8'h0C
`define AESSC_OFF_CMD 8'h10
`define AESSC_OFF_CTRL 8'h14
`define AESSC_ENV1_RST 32'h0000_0000
`define AESSC_PRMD_RST 32'h0000_0000
`define AESSC_ENV1_STAM 18
`define AESSC_ENV1_STPM 19
`define AESSC_ENV1_PCSL 24
`define AESSC_ENV1_PCSM 30
`define AESSC_PRMD_MSY_LO 18
`define AESSC_PRMD_MSY_HI 19
`define AESSC_PRMD_MSPE 24
`define AESSC_PRMD_ERROR_STOP_BROADCAST 25
`define AESSC_STS_STP 6
`define AESSC_STS_EMG 7
`define AESSC_STS_PCS 8
`define AESSC_ERR_STP 8
`define AESSC_ERR_EMG 9
`define AESSC_CMD_EMG 8'h05
`define AESSC_CMD_SHARED_STOP_LINE 8'h07
`define AESSC_CMD_STOP_IMM 8'h49
`define AESSC_CMD_STOP_DEC 8'h4A
`define AESSC_CMD_START_CONST 8'h50
`define AESSC_CMD_START_HIGH 8'h52
`define AESSC_CMD_ERROR_STOP 8'h60
`define AESSC_ONESHOT_CYC 4'h8
`define AESSC_DECEL_CYC 8'h40
`define AESSC_COND_STOP 4'h0
`define AESSC_COND_WAIT 4'h2
`define AESSC_COND_RUN 4'h8
`define AESSC_COND_DECEL 4'h9
`endif

// [inc/aessc_pkg.sv]
// types shared by the start/stop control block
package aessc_pkg;
  typedef enum logic [1:0] {
    AESSC_IDLE = 2'b00,
    AESSC_WAIT = 2'b01,
    AESSC_RUN = 2'b10,
    AESSC_DECEL = 2'b11
  } aessc_state_t;
endpackage

// [rtl/aessc_axis_ctrl.sv]
// axis external start, stop and emergency-stop control with registers
// Functional notes
// - override pin with start wait mode 01 starts only this axis
// - override pin polarity bit: 0 active low, 1 active high
// - extension status bit 8 shows override input state
// - stop enable set: low shared stop line stops running axis
// - deceleration stop only for high speed start; constant speed stops now
// - stop method bit: 0 immediate, 1 deceleration
// - shared stop line is fixed active low
// - command 07h drives 8-cycle low pulse and senses it back
// - broadcast bit set: error stop drives 8-cycle pulse on stop line
// - own stop commands still stop this axis with lines tied
// - stop by stop line sets error cause bit 8
// - extension status bit 6 shows stop line state
// - emergency input low or command 05h stops immediately
// - no operation while emergency input is low
// - emergency input is fixed active low
// - emergency input stop sets error cause bit 9; command 05h does not
// - extension status bit 7 shows emergency input state
// - emergency stop may cut last pulse; software must re-home
// - start trigger bit: 0 level, 1 edge (override pin only; start line never fires in edge mode)
// - waiting for external start reads status code 0010
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "aessc_defs.svh"
module aessc_axis_ctrl
  import aessc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_position_override_input,
  input wire logic i_shared_stop_line,
  output logic o_shared_stop_line,
  output logic o_shared_stop_line_oe,
  input wire logic i_emergency_stop_input,
  input wire logic i_start_line_n,
  output logic o_pulse_enable,
  output logic o_running
);

  logic [31:0] env1_r;
  logic [31:0] prmd_r;
  logic [1:0] err_r;
  logic [2:0] pcs_sync_r;
  logic [2:0] stp_sync_r;
  logic [1:0] emg_sync_r;
  logic [1:0] sta_sync_r;
  logic [3:0] shot_cnt_r;
  logic [7:0] dec_cnt_r;
  logic high_speed_r;
  aessc_state_t state_r;
  aessc_state_t state_nxt;

  logic wr_cmd;
  logic [7:0] cmd;
  logic pcs_on;
  logic pcs_prev_on;
  logic stp_on;
  logic emg_on;
  logic sta_on;
  logic sta_prev_on;
  logic start_src;
  logic start_prev;
  logic start_fire;
  logic active;
  logic line_stop;
  logic line_decel;
  logic emg_stop;
  logic err_stop;
  logic shot_req;

  // second stage feeds logic; only the override uses its third stage, to remember for edges
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pcs_sync_r <= 3'h0;
      stp_sync_r <= 3'h7;
      emg_sync_r <= 2'h3;
      sta_sync_r <= 2'h3;
    end else begin
      pcs_sync_r <= {pcs_sync_r[1:0], i_position_override_input};
      stp_sync_r <= {stp_sync_r[1:0], i_shared_stop_line};
      emg_sync_r <= {emg_sync_r[0], i_emergency_stop_input};
      sta_sync_r <= {sta_sync_r[0], i_start_line_n};
    end
  end

  assign pcs_on = pcs_sync_r[1] ~^ env1_r[`AESSC_ENV1_PCSL];
  assign pcs_prev_on = pcs_sync_r[2] ~^ env1_r[`AESSC_ENV1_PCSL];
  assign stp_on = ~stp_sync_r[1];
  assign emg_on = ~emg_sync_r[1];
  assign sta_on = ~sta_sync_r[1];
  assign sta_prev_on = ~sta_sync_r[1];

  assign wr_cmd = i_wr && (i_addr == `AESSC_OFF_CMD);
  assign cmd = i_wdata[7:0];

  // the override pin replaces the shared start line for this axis only
  assign start_src = env1_r[`AESSC_ENV1_PCSM] ? pcs_on : sta_on;
  assign start_prev = env1_r[`AESSC_ENV1_PCSM] ? pcs_prev_on : sta_prev_on;
  // edge mode fires once on override turn-on, never from the start line; level mode fires while on
  assign start_fire = env1_r[`AESSC_ENV1_STAM] ?
                      (start_src && !start_prev) : start_src;

  assign active = (state_r == AESSC_RUN) || (state_r == AESSC_DECEL);
  assign line_stop = active && prmd_r[`AESSC_PRMD_MSPE] && stp_on;
  // constant-speed starts have no ramp, so they always stop at once
  assign line_decel = env1_r[`AESSC_ENV1_STPM] && high_speed_r;
  // emergency stop halts every state, including the wait for start
  assign emg_stop = (state_r != AESSC_IDLE) &&
                    (emg_on || (wr_cmd && cmd == `AESSC_CMD_EMG));
  assign err_stop = active && wr_cmd && (cmd == `AESSC_CMD_ERROR_STOP);
  assign shot_req = (wr_cmd && cmd == `AESSC_CMD_SHARED_STOP_LINE) ||
                    (err_stop && prmd_r[`AESSC_PRMD_ERROR_STOP_BROADCAST]);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      env1_r <= `AESSC_ENV1_RST;
      prmd_r <= `AESSC_PRMD_RST;
    end else if (i_wr) begin
      if (i_addr == `AESSC_OFF_ENV1) begin
        env1_r <= i_wdata;
      end
      if (i_addr == `AESSC_OFF_PRMD) begin
        prmd_r <= i_wdata;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      AESSC_IDLE: begin
        // starts are refused while the emergency input is held
        if (wr_cmd && !emg_on) begin
          if (cmd == `AESSC_CMD_START_CONST ||
              cmd == `AESSC_CMD_START_HIGH) begin
            if (prmd_r[`AESSC_PRMD_MSY_HI:`AESSC_PRMD_MSY_LO] == 2'b01) begin
              state_nxt = AESSC_WAIT;
            end else begin
              state_nxt = AESSC_RUN;
            end
          end
        end
      end
      AESSC_WAIT: begin
        if (emg_stop) begin
          state_nxt = AESSC_IDLE;
        end else if (wr_cmd && (cmd == `AESSC_CMD_STOP_IMM ||
                                cmd == `AESSC_CMD_STOP_DEC)) begin
          state_nxt = AESSC_IDLE;
        end else if (start_fire) begin
          state_nxt = AESSC_RUN;
        end
      end
      AESSC_RUN: begin
        if (emg_stop || err_stop) begin
          state_nxt = AESSC_IDLE;
        end else if (wr_cmd && cmd == `AESSC_CMD_STOP_IMM) begin
          state_nxt = AESSC_IDLE;
        end else if (wr_cmd && cmd == `AESSC_CMD_STOP_DEC) begin
          state_nxt = high_speed_r ? AESSC_DECEL : AESSC_IDLE;
        end else if (line_stop) begin
          state_nxt = line_decel ? AESSC_DECEL : AESSC_IDLE;
        end
      end
      AESSC_DECEL: begin
        if (emg_stop || err_stop) begin
          state_nxt = AESSC_IDLE;
        end else if (wr_cmd && cmd == `AESSC_CMD_STOP_IMM) begin
          state_nxt = AESSC_IDLE;
        end else if (line_stop && !line_decel) begin
          state_nxt = AESSC_IDLE;
        end else if (dec_cnt_r == 8'h00) begin
          state_nxt = AESSC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= AESSC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the ramp itself lives elsewhere; a fixed count stands in for it
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dec_cnt_r <= 8'h00;
    end else if (state_r != AESSC_DECEL) begin
      dec_cnt_r <= `AESSC_DECEL_CYC;
    end else if (dec_cnt_r != 8'h00) begin
      dec_cnt_r <= dec_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      high_speed_r <= 1'b0;
    end else if (state_r == AESSC_IDLE && wr_cmd) begin
      high_speed_r <= (cmd == `AESSC_CMD_START_HIGH);
    end
  end

  // error causes are sticky; a read clears them but a new cause wins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_r <= 2'h0;
    end else begin
      if (i_rd && i_addr == `AESSC_OFF_ERR) begin
        err_r <= 2'h0;
      end
      if (line_stop && !emg_stop && !err_stop && state_nxt != state_r) begin
        err_r[0] <= 1'b1;
      end
      if (emg_stop && emg_on) begin
        err_r[1] <= 1'b1;
      end
    end
  end

  // drives low only; released otherwise so others can share the line
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shot_cnt_r <= 4'h0;
    end else if (shot_req) begin
      shot_cnt_r <= `AESSC_ONESHOT_CYC;
    end else if (shot_cnt_r != 4'h0) begin
      shot_cnt_r <= shot_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_shared_stop_line <= 1'b0;
      o_shared_stop_line_oe <= 1'b0;
    end else begin
      o_shared_stop_line <= 1'b0;
      o_shared_stop_line_oe <= shot_req || (shot_cnt_r > 4'h1);
    end
  end

  // the pulse output is cut the cycle the state drops, so the last
  // step may be short; software has to re-home after an emergency stop
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pulse_enable <= 1'b0;
      o_running <= 1'b0;
    end else begin
      o_pulse_enable <= (state_nxt == AESSC_RUN) ||
                        (state_nxt == AESSC_DECEL);
      o_running <= state_nxt != AESSC_IDLE;
    end
  end

  function automatic logic [3:0] cond_code(input aessc_state_t s);
    unique case (s)
      AESSC_IDLE: cond_code = `AESSC_COND_STOP;
      AESSC_WAIT: cond_code = `AESSC_COND_WAIT;
      AESSC_RUN: cond_code = `AESSC_COND_RUN;
      AESSC_DECEL: cond_code = `AESSC_COND_DECEL;
    endcase
  endfunction

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= 32'h0000_0000;
      unique case (i_addr)
        `AESSC_OFF_ENV1: o_rdata <= env1_r;
        `AESSC_OFF_PRMD: o_rdata <= prmd_r;
        `AESSC_OFF_STS: begin
          o_rdata[3:0] <= cond_code(state_r);
          o_rdata[`AESSC_STS_STP] <= stp_on;
          o_rdata[`AESSC_STS_EMG] <= emg_on;
          o_rdata[`AESSC_STS_PCS] <= pcs_on;
        end
        `AESSC_OFF_ERR: begin
          o_rdata[`AESSC_ERR_STP] <= err_r[0];
          o_rdata[`AESSC_ERR_EMG] <= err_r[1];
        end
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule // aessc_axis_ctrl

// [dv/aessc_axis_props.sv]
// assertions on the start/stop control block ports
`timescale 1ns/10ps
`include "aessc_defs.svh"
module aessc_axis_props (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_shared_stop_line,
  input wire logic o_shared_stop_line,
  input wire logic o_shared_stop_line_oe,
  input wire logic i_emergency_stop_input,
  input wire logic o_pulse_enable,
  input wire logic o_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  property p_oneshot;
    i_wr && i_addr == `AESSC_OFF_CMD && i_wdata[7:0] == `AESSC_CMD_SHARED_STOP_LINE
      |=> o_shared_stop_line_oe [*8] ##1 !o_shared_stop_line_oe;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("bad pulse");
  property p_drive_low;
    o_shared_stop_line == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drove high");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_unmap;
    i_rd && i_addr == 8'h14 |=> o_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_emg_hold;
    !i_emergency_stop_input [*5] |-> !o_running;
  endproperty
  a_emg_hold: assert property (p_emg_hold) else $error("ran in emg");
  property p_emg_cmd;
    i_wr && i_addr == `AESSC_OFF_CMD && i_wdata[7:0] == `AESSC_CMD_EMG
      |-> ##[1:3] !o_running;
  endproperty
  a_emg_cmd: assert property (p_emg_cmd) else $error("no emg stop");
  property p_emg_sts;
    !i_emergency_stop_input [*4] ##0 (i_rd && i_addr == `AESSC_OFF_STS)
      |=> o_rdata[7];
  endproperty
  a_emg_sts: assert property (p_emg_sts) else $error("emg status");
  property p_emg_off;
    i_emergency_stop_input [*4] ##0 (i_rd && i_addr == `AESSC_OFF_STS)
      |=> !o_rdata[7];
  endproperty
  a_emg_off: assert property (p_emg_off) else $error("emg polarity");
  property p_stp_sts;
    !i_shared_stop_line [*4] ##0 (i_rd && i_addr == `AESSC_OFF_STS)
      |=> o_rdata[6];
  endproperty
  a_stp_sts: assert property (p_stp_sts) else $error("line status");
  property p_pulse_run;
    o_pulse_enable |-> o_running;
  endproperty
  a_pulse_run: assert property (p_pulse_run) else $error("pulse idle");
endmodule // aessc_axis_props

// [dv/aessc_stop_partner.sv]
// outside stop circuit on the shared open-drain stop wire
`timescale 1ns/10ps
module aessc_stop_partner (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_go,
  input wire logic i_clr,
  input wire logic i_dut_oe,
  output logic o_wire,
  output logic [7:0] o_low_cnt
);
  logic [2:0] pull_r;
  // the shortest pulse allowed, to catch a slow input filter
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) pull_r <= 3'h0;
    else if (i_go) pull_r <= 3'h4;
    else if (pull_r != 3'h0) pull_r <= pull_r - 3'h1;
  end
  // pull-up on the wire: high when nobody pulls
  assign o_wire = ~(i_dut_oe | (pull_r != 3'h0));
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) o_low_cnt <= 8'h0;
    else if (i_clr) o_low_cnt <= 8'h0;
    else if (!o_wire) o_low_cnt <= o_low_cnt + 8'h1;
  end
endmodule // aessc_stop_partner

// [dv/aessc_axis_ctrl_bench.sv]
// bench for the start/stop control block
`timescale 1ns/10ps
`include "aessc_defs.svh"
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module aessc_axis_ctrl_bench;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic position_override_input = 1'b0;
  logic emg = 1'b1;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic [31:0] o_rdata, v;
  logic wire_lvl, oe, pen, run;
  logic [7:0] low_cnt;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #25 i_clock = ~i_clock;
  aessc_axis_ctrl aessc_axis_ctrl_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_position_override_input(position_override_input), .i_shared_stop_line(wire_lvl),
    .o_shared_stop_line(), .o_shared_stop_line_oe(oe),
    .i_emergency_stop_input(emg), .i_start_line_n(1'b1),
    .o_pulse_enable(pen), .o_running(run));
  aessc_stop_partner aessc_stop_partner_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_go(go), .i_clr(clr), .i_dut_oe(oe),
    .o_wire(wire_lvl), .o_low_cnt(low_cnt));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(`AESSC_OFF_CMD, {24'h0, c});
  endtask
  task automatic chk(input string n, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 v = o_rdata & m;
    `CHK(n, e, v)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    tick(12);
    i_reset_n <= 1'b1;
    tick(2);
    chk("env1", `AESSC_OFF_ENV1, 32'hFFFF_FFFF, 32'h0);
    chk("unmap", 8'h14, 32'hFFFF_FFFF, 32'h0);
    wr(`AESSC_OFF_PRMD, 32'h0100_0000);
    chk("prmd", `AESSC_OFF_PRMD, 32'hFFFF_FFFF, 32'h0100_0000);
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    chk("run", `AESSC_OFF_STS, 32'hF, 32'h8);
    `CHK("busy", 2'h3, {pen, run})
    cmd(`AESSC_CMD_SHARED_STOP_LINE);
    tick(3);
    chk("line on", `AESSC_OFF_STS, 32'h4F, 32'h40);
    chk("cause", `AESSC_OFF_ERR, 32'h300, 32'h100);
    chk("cleared", `AESSC_OFF_ERR, 32'h300, 32'h0);
    wr(`AESSC_OFF_ENV1, 32'h0008_0000);
    cmd(`AESSC_CMD_START_HIGH);
    tick(2);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(4);
    chk("decel", `AESSC_OFF_STS, 32'hF, 32'h9);
    tick(70);
    chk("decel end", `AESSC_OFF_STS, 32'hF, 32'h0);
    chk("ext cause", `AESSC_OFF_ERR, 32'h300, 32'h100);
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(4);
    chk("const imm", `AESSC_OFF_STS, 32'hF, 32'h0);
    chk("const cause", `AESSC_OFF_ERR, 32'h300, 32'h100);
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    cmd(`AESSC_CMD_STOP_IMM);
    tick(2);
    chk("own stop", `AESSC_OFF_STS, 32'hF, 32'h0);
    chk("own cause", `AESSC_OFF_ERR, 32'h300, 32'h0);
    wr(`AESSC_OFF_PRMD, 32'h0300_0000);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    cmd(`AESSC_CMD_START_CONST);
    cmd(`AESSC_CMD_ERROR_STOP);
    tick(12);
    `CHK("bcast", 8'h8, low_cnt)
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    emg <= 1'b0;
    tick(5);
    chk("emg", `AESSC_OFF_STS, 32'h8F, 32'h80);
    chk("emg cause", `AESSC_OFF_ERR, 32'h300, 32'h200);
    cmd(`AESSC_CMD_START_CONST);
    tick(3);
    chk("refused", `AESSC_OFF_STS, 32'hF, 32'h0);
    emg <= 1'b1;
    tick(4);
    chk("emg off", `AESSC_OFF_STS, 32'h80, 32'h0);
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    cmd(`AESSC_CMD_EMG);
    tick(2);
    chk("emg cmd", `AESSC_OFF_STS, 32'hF, 32'h0);
    chk("cmd cause", `AESSC_OFF_ERR, 32'h300, 32'h0);
    wr(`AESSC_OFF_ENV1, 32'h4100_0000);
    wr(`AESSC_OFF_PRMD, 32'h0004_0000);
    cmd(`AESSC_CMD_START_CONST);
    tick(2);
    chk("wait", `AESSC_OFF_STS, 32'h10F, 32'h2);
    position_override_input <= 1'b1;
    tick(4);
    chk("pcs go", `AESSC_OFF_STS, 32'h10F, 32'h108);
    cmd(`AESSC_CMD_STOP_IMM);
    wr(`AESSC_OFF_ENV1, 32'h4000_0000);
    tick(4);
    chk("pcs low", `AESSC_OFF_STS, 32'h100, 32'h0);
    final_report();
  end
endmodule // aessc_axis_ctrl_bench
bind aessc_axis_ctrl aessc_axis_props aessc_axis_props_inst (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_shared_stop_line(i_shared_stop_line),
  .o_shared_stop_line(o_shared_stop_line),
  .o_shared_stop_line_oe(o_shared_stop_line_oe),
  .i_emergency_stop_input(i_emergency_stop_input),
  .o_pulse_enable(o_pulse_enable), .o_running(o_running));
